// ===== verilog/tcic_top.v
`timescale 1ns/100ps
`include "tcic_defs.vh"
module tcic_top (
  clk_sys,
  reset_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  deadtime_sample_clock,
  timer_input_clock,
  channel_capture_enable,
  own_timer_input_line,
  neighbour_timer_input_line,
  trigger_edge_signal,
  channel_is_input,
  filtered_own_line,
  capture_event
);
  input wire clk_sys;
  input wire reset_n;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  // one-cycle enables at the two base rates
  input wire deadtime_sample_clock;
  input wire timer_input_clock;
  input wire channel_capture_enable;
  input wire own_timer_input_line;
  // already filtered by channel 2
  input wire neighbour_timer_input_line;
  input wire trigger_edge_signal;
  output reg channel_is_input;
  output wire filtered_own_line;
  output reg capture_event;

  reg rst_meta_ff;
  reg rst_sync_ff;
  reg [1:0] capture_event_prescale_ff;
  reg [1:0] capture_source_select_ff;
  reg [3:0] input_line_filter_setting_ff;
  reg [4:0] div_ff;
  reg [2:0] psc_cnt_ff;
  reg src_prev_ff;
  reg raw_ff;
  reg [3:0] n_count;
  reg sample_en;
  reg src_level;
  reg src_edge;
  reg [2:0] psc_limit;
  wire rst_n;
  wire cfg_hit;
  wire [31:0] cfg_word;
  wire [11:0] cfg_offset;
  wire flt_line;

  assign rst_n = rst_sync_ff;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // zero-wait APB slave; unmapped addresses read zero, no error
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign cfg_offset = `TCIC_CFG_OFFSET;
  assign cfg_hit = (paddr[11:2] == cfg_offset[11:2]);
  assign cfg_word = {12'h000, capture_event_prescale_ff, capture_source_select_ff, 12'h000,
                     input_line_filter_setting_ff};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      capture_event_prescale_ff <= 2'h0;
      capture_source_select_ff <= 2'h0;
      input_line_filter_setting_ff <= 4'h0;
    end else if (psel && penable && pwrite && cfg_hit) begin
      capture_event_prescale_ff <= pwdata[`TCIC_PSC_MSB:`TCIC_PSC_LSB];
      input_line_filter_setting_ff <= pwdata[`TCIC_FLT_MSB:`TCIC_FLT_LSB];
      if (!channel_capture_enable) begin
        capture_source_select_ff <= pwdata[`TCIC_CCS_MSB:`TCIC_CCS_LSB];
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= cfg_hit ? cfg_word : 32'h00000000;
    end
  end

  // divider of the dead-time enable, free-running so rate changes take effect at once
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 5'h00;
    end else if (deadtime_sample_clock) begin
      div_ff <= div_ff + 5'h01;
    end
  end

  // sampling rate and event count per filter code
  always @* begin
    sample_en = 1'b0;
    n_count = 4'h1;
    case (input_line_filter_setting_ff)
      4'h0: begin
        sample_en = deadtime_sample_clock;
        n_count = 4'h1;
      end
      4'h1: begin
        sample_en = timer_input_clock;
        n_count = 4'h2;
      end
      4'h2: begin
        sample_en = timer_input_clock;
        n_count = 4'h4;
      end
      4'h3: begin
        sample_en = timer_input_clock;
        n_count = 4'h8;
      end
      4'h4, 4'h5: begin
        sample_en = deadtime_sample_clock && (div_ff[0] == 1'b1);
        n_count = input_line_filter_setting_ff[0] ? 4'h8 : 4'h6;
      end
      4'h6, 4'h7: begin
        sample_en = deadtime_sample_clock && (div_ff[1:0] == 2'h3);
        n_count = input_line_filter_setting_ff[0] ? 4'h8 : 4'h6;
      end
      4'h8, 4'h9: begin
        sample_en = deadtime_sample_clock && (div_ff[2:0] == 3'h7);
        n_count = input_line_filter_setting_ff[0] ? 4'h8 : 4'h6;
      end
      4'hA, 4'hB, 4'hC: begin
        sample_en = deadtime_sample_clock && (div_ff[3:0] == 4'hF);
        n_count = (input_line_filter_setting_ff == 4'hA) ? 4'h5 :
                  (input_line_filter_setting_ff == 4'hB) ? 4'h6 : 4'h8;
      end
      4'hD, 4'hE, 4'hF: begin
        sample_en = deadtime_sample_clock && (div_ff == `TCIC_DTS_DIV_MAX);
        n_count = (input_line_filter_setting_ff == 4'hD) ? 4'h5 :
                  (input_line_filter_setting_ff == 4'hE) ? 4'h6 : 4'h8;
      end
      default: begin
        sample_en = 1'b0;
        n_count = 4'h1;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      raw_ff <= 1'b0;
    end else begin
      raw_ff <= own_timer_input_line;
    end
  end

  tcic_filter u_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .n_count(n_count),
    .line_in(raw_ff),
    .line_out(flt_line)
  );

  assign filtered_own_line = flt_line;

  // source select; trigger edge is already an edge pulse
  always @* begin
    src_level = 1'b0;
    src_edge = 1'b0;
    case (capture_source_select_ff)
      `TCIC_CCS_OWN: begin
        src_level = flt_line;
        src_edge = flt_line && !src_prev_ff;
      end
      `TCIC_CCS_NEIGH: begin
        src_level = neighbour_timer_input_line;
        src_edge = neighbour_timer_input_line && !src_prev_ff;
      end
      `TCIC_CCS_TRIG: begin
        src_edge = trigger_edge_signal;
      end
      default: begin
        src_edge = 1'b0;
      end
    endcase
  end

  always @* begin
    case (capture_event_prescale_ff)
      2'h0: psc_limit = 3'h0;
      2'h1: psc_limit = 3'h1;
      2'h2: psc_limit = 3'h3;
      default: psc_limit = 3'h7;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_ff <= 1'b0;
      psc_cnt_ff <= 3'h0;
      capture_event <= 1'b0;
      channel_is_input <= 1'b0;
    end else begin
      src_prev_ff <= src_level;
      channel_is_input <= (capture_source_select_ff != `TCIC_CCS_OUTPUT);
      capture_event <= 1'b0;
      if (!channel_capture_enable) begin
        psc_cnt_ff <= 3'h0;
      end else if (src_edge) begin
        if (psc_cnt_ff >= psc_limit) begin
          psc_cnt_ff <= 3'h0;
          capture_event <= 1'b1;
        end else begin
          psc_cnt_ff <= psc_cnt_ff + 3'h1;
        end
      end
    end
  end
endmodule

// ===== verilog/tcic_defs.vh
// What this block does
// - prescaler 00 passes every event, 01 one in 2, 10 one in 4, 11 one in 8.
// - prescaler counter clears whenever the channel capture enable is low.
// - select 00 output, 01 own filtered input, 10 neighbour filtered input.
// - select 11 takes the trigger controller edge signal as capture source.
// - select field writes only while channel capture enable is zero.
// - filter is an N-event counter; new level passes after N confirming samples.
// - filter code 0000 means no filtering, sampling at dead-time clock rate.
// - codes 0001..0011 sample at timer input clock with N of 2, 4, 8.
// - codes 0100..0111 sample at dead-time clock /2 or /4 with N 6 or 8.
// - codes 1000 and 1001 sample at dead-time clock /8 with N 6 and 8.
// - codes 1010..1100 sample at dead-time clock /16 with N 5, 6, 8.
// - codes 1101..1111 sample at dead-time clock /32 with N 5, 6, 8.
`ifndef TCIC_DEFS_VH
`define TCIC_DEFS_VH
`define TCIC_CFG_OFFSET 12'h02C
`define TCIC_CFG_RESET 32'h00000000
`define TCIC_PSC_MSB 19
`define TCIC_PSC_LSB 18
`define TCIC_CCS_MSB 17
`define TCIC_CCS_LSB 16
`define TCIC_FLT_MSB 3
`define TCIC_FLT_LSB 0
`define TCIC_CCS_OUTPUT 2'h0
`define TCIC_CCS_OWN 2'h1
`define TCIC_CCS_NEIGH 2'h2
`define TCIC_CCS_TRIG 2'h3
`define TCIC_DTS_DIV_MAX 5'h1F
`endif

// ===== verilog/tcic_filter.v
`timescale 1ns/100ps
`include "tcic_defs.vh"
module tcic_filter (
  clk_sys,
  rst_n,
  sample_en,
  n_count,
  line_in,
  line_out
);
  input wire clk_sys;
  input wire rst_n;
  input wire sample_en;
  input wire [3:0] n_count;
  input wire line_in;
  output wire line_out;

  reg level_ff;
  reg [3:0] cnt_ff;

  assign line_out = level_ff;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else if (sample_en) begin
      if (line_in == level_ff) begin
        cnt_ff <= 4'h0;
      end else if (cnt_ff + 4'h1 >= n_count) begin
        level_ff <= line_in;
        cnt_ff <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule

// ===== tb/tcic_far.sv
`timescale 1ns/100ps
module tcic_far (
  input wire logic clk_sys,
  output logic dts_pulse,
  output logic clkin_pulse
);
  logic [1:0] div_ff = 2'h0;
  // dead-time enable every cycle, so any divider phase gives the same rate
  assign dts_pulse = 1'h1;
  assign clkin_pulse = (div_ff == 2'h2);
  always @(posedge clk_sys) begin
    div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
  end
endmodule

// ===== tb/tcic_chk.sv
`timescale 1ns/100ps
module tcic_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic channel_capture_enable,
  input wire logic own_timer_input_line,
  input wire logic channel_is_input,
  input wire logic filtered_own_line,
  input wire logic capture_event
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_bus_ready: assert property (pready) else $error("pready low");
  a_bus_noerr: assert property (!pslverr) else $error("pslverr high");
  a_ev_enabled: assert property (capture_event |-> $past(channel_capture_enable))
    else $error("capture while disabled");
  a_off_quiet: assert property (!channel_capture_enable [*2] |-> !capture_event)
    else $error("capture with channel off");
  a_out_quiet: assert property (!channel_is_input [*3] |-> !capture_event)
    else $error("capture in output mode");
  a_sel_frozen: assert property (channel_capture_enable [*3] |-> $stable(channel_is_input))
    else $error("select changed while enabled");
  a_filt_confirm: assert property ($changed(filtered_own_line) |->
    $past(own_timer_input_line, 2) == filtered_own_line) else $error("filter unconfirmed");
  // a steady input that already agrees with the output must never move it
  a_filt_hold: assert property ((own_timer_input_line == filtered_own_line &&
    $stable(own_timer_input_line)) [*3] |=>
    $stable(filtered_own_line)) else $error("filter moved on agreement");
  c_capture: cover property (capture_event);
  c_filt_rise: cover property ($rose(filtered_own_line));
  c_input_on: cover property (channel_is_input && channel_capture_enable);
endmodule
bind tcic_top tcic_chk u_chk (.*);

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, dts, ci, is_in, filt, cap;
  logic en = 1'h0, own = 1'h0, nb = 1'h0, trig = 1'h0;
  int bad_count = 0, total_checks = 0, ev = 0, cnt, lo, hi;
  int nt[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  int pt[16] = '{1, 3, 3, 3, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
  always #5 clk_sys = ~clk_sys;
  // counted on the falling edge to stay clear of the capture register update
  always @(negedge clk_sys) if (cap === 1'h1) ev++;
  tcic_far far (.clk_sys(clk_sys), .dts_pulse(dts), .clkin_pulse(ci));
  tcic_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .deadtime_sample_clock(dts), .timer_input_clock(ci),
    .channel_capture_enable(en), .own_timer_input_line(own),
    .neighbour_timer_input_line(nb), .trigger_edge_signal(trig),
    .channel_is_input(is_in), .filtered_own_line(filt), .capture_event(cap));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) begin
      bad_count++;
      wrap_up;
    end
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic tp;
    trig <= 1'h1;
    @(posedge clk_sys);
    trig <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic lp(input logic o);
    if (o) own <= 1'h1;
    else nb <= 1'h1;
    repeat (4) @(posedge clk_sys);
    own <= 1'h0;
    nb <= 1'h0;
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (3) @(posedge clk_sys);
    apb(1'h0, 12'h02C, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'h0, 12'h030, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'h1, 12'h02C, 32'hFFFFFFFF);
    apb(1'h0, 12'h02C, 32'h00000000);
    chk(rd, 32'h000F000F);
    en <= 1'h1;
    apb(1'h1, 12'h02C, 32'h00010000);
    apb(1'h0, 12'h02C, 32'h00000000);
    chk(rd, 32'h00030000);
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      en <= 1'h0;
      apb(1'h1, 12'h02C, {12'h000, p[1:0], 18'h30000});
      en <= 1'h1;
      cnt = ev;
      repeat (8) tp;
      repeat (3) @(posedge clk_sys);
      chk(ev - cnt, 8 >> p);
      tp;
    end
    for (int s = 0; s < 3; s++) begin
      en <= 1'h0;
      apb(1'h1, 12'h02C, {14'h0000, s[1:0], 16'h0000});
      en <= 1'h1;
      cnt = ev;
      repeat (2) lp(1'h1);
      lp(1'h0);
      chk(ev - cnt, s == 0 ? 0 : 3 - s);
      chk(is_in, s != 0);
    end
    $display("test capture done");
    en <= 1'h0;
    for (int c = 0; c < 16; c++) begin
      apb(1'h1, 12'h02C, {28'h0000000, c[3:0]});
      lo = (nt[c] - 1) * pt[c];
      hi = (nt[c] + 1) * pt[c] + 4;
      for (int v = 1; v >= 0; v--) begin
        own <= v[0];
        repeat (pt[c]) @(posedge clk_sys);
        own <= !v[0];
        repeat (2 * pt[c] + 2) @(posedge clk_sys);
        if (c != 0) chk(filt, !v[0]);
        own <= v[0];
        cnt = 0;
        do begin
          @(posedge clk_sys);
          cnt++;
        end while (filt !== v[0] && cnt < 400);
        chk(cnt >= lo && cnt <= hi, 1);
      end
    end
    $display("test filter done");
    wrap_up;
  end
endmodule
